// file: cbdu_defines.vh
// register indices, field positions and codes for the core breakpoint debug unit
`ifndef CBDU_DEFINES_VH
`define CBDU_DEFINES_VH

// register indices; byte address is four times the index
`define CBDU_IDX_SSR_COPY   8'h10
`define CBDU_IDX_PC_COPY    8'h11
`define CBDU_IDX_SP_COPY    8'h12
`define CBDU_IDX_RR_CORE    8'h13
`define CBDU_IDX_RR_REG     8'h14
`define CBDU_IDX_CAUSE      8'h15
`define CBDU_IDX_CAUSE_DATA 8'h16
`define CBDU_IDX_STOP_MASK  8'h18
`define CBDU_IDX_SCRATCH    8'h20
`define CBDU_IDX_IBP_ADDR   8'h30
`define CBDU_IDX_IBP_CTRL   8'h40
`define CBDU_IDX_DWP_ADDR1  8'h50
`define CBDU_IDX_DWP_ADDR2  8'h60
`define CBDU_IDX_DWP_CTRL   8'h70
`define CBDU_IDX_RWP_MASK   8'h80
`define CBDU_IDX_RWP_VALUE  8'h90
`define CBDU_IDX_RWP_CTRL   8'h9C

// control register fields
`define CBDU_CTRL_EN_BIT    0
`define CBDU_CTRL_INV_BIT   1
`define CBDU_CTRL_LOAD_BIT  2
`define CBDU_CTRL_CORE_LSB  16
`define CBDU_CTRL_CORE_MSB  23

// cause register fields
`define CBDU_CAUSE_IDX_LSB  16
`define CBDU_CAUSE_CORE_LSB 8

// cause codes
`define CBDU_CAUSE_NONE     3'h0
`define CBDU_CAUSE_HOST     3'h1
`define CBDU_CAUSE_DEBUG_CALL_INSTR    3'h2
`define CBDU_CAUSE_IBP      3'h3
`define CBDU_CAUSE_DWP      3'h4
`define CBDU_CAUSE_RWP      3'h5

`endif

// file: cbdu_core_breakpoint_debug_unit.v
// core breakpoint debug unit: debug registers, comparators and cause capture
`timescale 1ns/10ps
`default_nettype none
`include "cbdu_defines.vh"
module cbdu_core_breakpoint_debug_unit #(
  parameter NUM_CORES = 8,
  parameter NUM_CMP   = 4
) (
  input  wire        core_clk,
  input  wire        resetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        debugEntry,
  input  wire [31:0] savedStatusIn,
  input  wire [31:0] savedPcIn,
  input  wire [31:0] savedSpIn,
  input  wire        hostDebugReq,
  input  wire        debugCallValid,
  input  wire [7:0]  debugCallCore,
  input  wire        fetchValid,
  input  wire [7:0]  fetchCore,
  input  wire [31:0] fetchPc,
  input  wire        memValid,
  input  wire        memStore,
  input  wire [7:0]  memCore,
  input  wire [31:0] memAddr,
  input  wire        resValid,
  input  wire [7:0]  resCore,
  input  wire [31:0] resId,
  input  wire        inDebug,
  input  wire [2:0]  cfgScratchSel,
  input  wire        cfgScratchWrite,
  input  wire [31:0] cfgScratchWdata,
  output reg  [31:0] cfgScratchRdata,
  output reg         debugIrq,
  output reg  [7:0]  coreStop,
  output reg  [7:0]  regReadCore,
  output reg  [4:0]  regReadReg
);

  // **********************************************
  // functions
  // **********************************************
  function [1:0] lowIdx;
    input [3:0] hits;
    begin
      if (hits[0]) lowIdx = 2'h0;
      else if (hits[1]) lowIdx = 2'h1;
      else if (hits[2]) lowIdx = 2'h2;
      else lowIdx = 2'h3;
    end
  endfunction

  function coreOn;
    input [31:0] ctrl;
    input [7:0]  core;
    begin
      coreOn = (core < 8'h08) && ctrl[`CBDU_CTRL_CORE_LSB + core[2:0]];
    end
  endfunction

  // **********************************************
  // storage
  // **********************************************
  reg [31:0] ssrCopy_q;
  reg [31:0] pcCopy_q;
  reg [31:0] spCopy_q;
  reg [31:0] cause_q;
  reg [31:0] causeData_q;
  reg [7:0]  stopMask_q;
  reg [31:0] scratch_q [0:7];
  reg [31:0] ibpAddr_q [0:3];
  reg [31:0] ibpCtrl_q [0:3];
  reg [31:0] dwpA1_q   [0:3];
  reg [31:0] dwpA2_q   [0:3];
  reg [31:0] dwpCtrl_q [0:3];
  reg [31:0] rwpMask_q [0:3];
  reg [31:0] rwpVal_q  [0:3];
  reg [31:0] rwpCtrl_q [0:3];

  // **********************************************
  // apb decode
  // **********************************************
  wire [7:0] regIdx;
  wire       wordOk;
  wire       setup;
  wire       wrAcc;
  reg        hit;
  reg [31:0] rdVal;
  assign regIdx = paddr[9:2];
  assign wordOk = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0);
  assign setup  = psel && !penable;
  assign wrAcc  = psel && penable && pready && pwrite && wordOk && hit;

  always @* begin
    hit   = 1'b1;
    rdVal = 32'h0000_0000;
    case (regIdx)
      `CBDU_IDX_SSR_COPY:   rdVal = ssrCopy_q;
      `CBDU_IDX_PC_COPY:    rdVal = pcCopy_q;
      `CBDU_IDX_SP_COPY:    rdVal = spCopy_q;
      `CBDU_IDX_RR_CORE:    rdVal = {24'h0, regReadCore};
      `CBDU_IDX_RR_REG:     rdVal = {27'h0, regReadReg};
      `CBDU_IDX_CAUSE:      rdVal = cause_q;
      `CBDU_IDX_CAUSE_DATA: rdVal = causeData_q;
      `CBDU_IDX_STOP_MASK:  rdVal = {24'h0, stopMask_q};
      default: begin
        if (regIdx[7:3] == 5'h04) rdVal = scratch_q[regIdx[2:0]];
        else if (regIdx[7:2] == 6'h0C) rdVal = ibpAddr_q[regIdx[1:0]];
        else if (regIdx[7:2] == 6'h10) rdVal = ibpCtrl_q[regIdx[1:0]];
        else if (regIdx[7:2] == 6'h14) rdVal = dwpA1_q[regIdx[1:0]];
        else if (regIdx[7:2] == 6'h18) rdVal = dwpA2_q[regIdx[1:0]];
        else if (regIdx[7:2] == 6'h1C) rdVal = dwpCtrl_q[regIdx[1:0]];
        else if (regIdx[7:2] == 6'h20) rdVal = rwpMask_q[regIdx[1:0]];
        else if (regIdx[7:2] == 6'h24) rdVal = rwpVal_q[regIdx[1:0]];
        else if (regIdx[7:2] == 6'h27) rdVal = rwpCtrl_q[regIdx[1:0]];
        else hit = 1'b0;
      end
    endcase
  end

  // no wait state: pready rises in the first access cycle
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup;
      pslverr <= setup && !(wordOk && hit);
      prdata  <= (setup && !pwrite && wordOk && hit) ? rdVal : 32'h0000_0000;
    end
  end

  // **********************************************
  // comparators
  // **********************************************
  reg [3:0]  ibpHit;
  reg [3:0]  dwpHit;
  reg [3:0]  rwpHit;
  reg        inRange;
  reg        resEq;
  integer    i;

  always @* begin
    ibpHit  = 4'h0;
    dwpHit  = 4'h0;
    rwpHit  = 4'h0;
    inRange = 1'b0;
    resEq   = 1'b0;
    for (i = 0; i < NUM_CMP; i = i + 1) begin
      ibpHit[i] = fetchValid && ibpCtrl_q[i][`CBDU_CTRL_EN_BIT]
                  && coreOn(ibpCtrl_q[i], fetchCore)
                  && ((fetchPc == ibpAddr_q[i]) ^ ibpCtrl_q[i][`CBDU_CTRL_INV_BIT]);
      inRange = (memAddr >= dwpA1_q[i]) && (memAddr <= dwpA2_q[i]);
      dwpHit[i] = memValid && dwpCtrl_q[i][`CBDU_CTRL_EN_BIT] && coreOn(dwpCtrl_q[i], memCore)
                  && (memStore || dwpCtrl_q[i][`CBDU_CTRL_LOAD_BIT])
                  && (dwpCtrl_q[i][`CBDU_CTRL_INV_BIT]
                      ? ((memAddr < dwpA1_q[i]) || (memAddr > dwpA2_q[i])) : inRange);
      resEq = ((resId & rwpMask_q[i]) == rwpVal_q[i]);
      rwpHit[i] = resValid && rwpCtrl_q[i][`CBDU_CTRL_EN_BIT] && coreOn(rwpCtrl_q[i], resCore)
                  && (resEq ^ rwpCtrl_q[i][`CBDU_CTRL_INV_BIT]);
    end
  end

  // **********************************************
  // register updates
  // **********************************************
  wire anyHit;
  assign anyHit = hostDebugReq || debugCallValid || (|ibpHit) || (|dwpHit) || (|rwpHit);
  integer k;

  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ssrCopy_q   <= 32'h0000_0000;
      pcCopy_q    <= 32'h0000_0000;
      spCopy_q    <= 32'h0000_0000;
      regReadCore <= 8'h00;
      regReadReg  <= 5'h00;
      cause_q     <= 32'h0000_0000;
      causeData_q <= 32'h0000_0000;
      stopMask_q  <= 8'h00;
      debugIrq    <= 1'b0;
      coreStop    <= 8'h00;
      cfgScratchRdata <= 32'h0000_0000;
      for (k = 0; k < 8; k = k + 1) scratch_q[k] <= 32'h0000_0000;
      for (k = 0; k < 4; k = k + 1) begin
        ibpAddr_q[k] <= 32'h0000_0000;
        ibpCtrl_q[k] <= 32'h0000_0000;
        dwpA1_q[k]   <= 32'h0000_0000;
        dwpA2_q[k]   <= 32'h0000_0000;
        dwpCtrl_q[k] <= 32'h0000_0000;
        rwpMask_q[k] <= 32'h0000_0000;
        rwpVal_q[k]  <= 32'h0000_0000;
        rwpCtrl_q[k] <= 32'h0000_0000;
      end
    end else begin
      // software writes first; hardware capture below wins in the same cycle
      if (wrAcc) begin
        case (regIdx)
          `CBDU_IDX_PC_COPY:    pcCopy_q <= pwdata;
          `CBDU_IDX_SP_COPY:    spCopy_q <= pwdata;
          `CBDU_IDX_RR_CORE:    regReadCore <= pwdata[7:0];
          `CBDU_IDX_RR_REG:     regReadReg <= pwdata[4:0];
          `CBDU_IDX_CAUSE:      cause_q <= {14'h0, pwdata[17:8], 5'h0, pwdata[2:0]};
          `CBDU_IDX_CAUSE_DATA: causeData_q <= pwdata;
          `CBDU_IDX_STOP_MASK:  stopMask_q <= pwdata[7:0];
          default: begin
            if (regIdx[7:3] == 5'h04) scratch_q[regIdx[2:0]] <= pwdata;
            else if (regIdx[7:2] == 6'h0C) ibpAddr_q[regIdx[1:0]] <= pwdata;
            else if (regIdx[7:2] == 6'h10) ibpCtrl_q[regIdx[1:0]] <= pwdata & 32'h00FF_0003;
            else if (regIdx[7:2] == 6'h14) dwpA1_q[regIdx[1:0]] <= pwdata;
            else if (regIdx[7:2] == 6'h18) dwpA2_q[regIdx[1:0]] <= pwdata;
            else if (regIdx[7:2] == 6'h1C) dwpCtrl_q[regIdx[1:0]] <= pwdata & 32'h00FF_0007;
            else if (regIdx[7:2] == 6'h20) rwpMask_q[regIdx[1:0]] <= pwdata;
            else if (regIdx[7:2] == 6'h24) rwpVal_q[regIdx[1:0]] <= pwdata;
            else if (regIdx[7:2] == 6'h27) rwpCtrl_q[regIdx[1:0]] <= pwdata & 32'h00FF_0003;
          end
        endcase
      end else if (cfgScratchWrite) begin
        scratch_q[cfgScratchSel] <= cfgScratchWdata;
      end
      cfgScratchRdata <= scratch_q[cfgScratchSel];
      if (debugEntry) begin
        ssrCopy_q <= savedStatusIn;
        pcCopy_q  <= savedPcIn;
        spCopy_q  <= savedSpIn;
      end
      debugIrq <= anyHit;
      if (anyHit) begin
        // priority: host, call, instruction, data, resource
        if (hostDebugReq) begin
          cause_q <= {29'h0, `CBDU_CAUSE_HOST};
        end else if (debugCallValid) begin
          cause_q <= {16'h0, debugCallCore, 5'h0, `CBDU_CAUSE_DEBUG_CALL_INSTR};
        end else if (|ibpHit) begin
          cause_q <= {14'h0, lowIdx(ibpHit), fetchCore, 5'h0, `CBDU_CAUSE_IBP};
        end else if (|dwpHit) begin
          cause_q     <= {14'h0, lowIdx(dwpHit), memCore, 5'h0, `CBDU_CAUSE_DWP};
          causeData_q <= memAddr;
        end else begin
          cause_q     <= {14'h0, lowIdx(rwpHit), resCore, 5'h0, `CBDU_CAUSE_RWP};
          causeData_q <= resId;
        end
      end
      coreStop <= inDebug ? 8'h00 : stopMask_q;
    end
  end

endmodule
`default_nettype wire

// file: cbdu_checker.sv
// port assertions for the core breakpoint debug unit
`timescale 1ns/10ps
`default_nettype none
module cbdu_checker (
  input wire logic        core_clk,
  input wire logic        resetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [31:0] prdata,
  input wire logic        hostDebugReq,
  input wire logic        debugCallValid,
  input wire logic        fetchValid,
  input wire logic        memValid,
  input wire logic        resValid,
  input wire logic        inDebug,
  input wire logic        debugIrq,
  input wire logic [7:0]  coreStop
);
  logic anyTrig;
  assign anyTrig = hostDebugReq | debugCallValid | fetchValid | memValid | resValid;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  sequence apbSetup;
    psel && !penable;
  endsequence
  ready_after_setup_a:
    assert property (apbSetup |=> pready) else $error("no ready after setup");
  ready_one_cycle_a:
    assert property (pready |=> !pready) else $error("ready held too long");
  err_with_ready_a:
    assert property (pslverr |-> pready) else $error("error without ready");
  rdata_idle_a:
    assert property (!pready |-> prdata == 32'h0) else $error("read data not idle");
  host_irq_a:
    assert property (hostDebugReq |=> debugIrq) else $error("host request lost");
  call_irq_a:
    assert property (debugCallValid |=> debugIrq) else $error("debug call lost");
  irq_has_cause_a:
    assert property (debugIrq |-> $past(anyTrig)) else $error("interrupt without trigger");
  stop_in_debug_a:
    assert property (inDebug |=> coreStop == 8'h00) else $error("cores stopped in debug");
endmodule
bind cbdu_core_breakpoint_debug_unit cbdu_checker chk (.*);
`default_nettype wire

// file: cbdu_core_model.sv
// behavioural model of the logical cores feeding the comparators
`timescale 1ns/10ps
`default_nettype none
module cbdu_core_model (
  input  wire logic        core_clk,
  output logic        fetchValid,
  output logic [7:0]  fetchCore,
  output logic [31:0] fetchPc,
  output logic        memValid,
  output logic        memStore,
  output logic [7:0]  memCore,
  output logic [31:0] memAddr,
  output logic        resValid,
  output logic [7:0]  resCore,
  output logic [31:0] resId
);
  initial {fetchValid, fetchCore, fetchPc, memValid, memStore, memCore, memAddr, resValid, resCore, resId} = '0;
  // one access for one cycle: kind 0 fetch, 1 memory, 2 resource
  task automatic issue(input int k, input logic [7:0] c, input logic [31:0] v, input logic st);
    fetchValid <= k == 0;
    memValid <= k == 1;
    resValid <= k == 2;
    {fetchCore, memCore, resCore} <= {3{c}};
    {fetchPc, memAddr, resId} <= {3{v}};
    memStore <= st;
    @(posedge core_clk);
    {fetchValid, memValid, resValid} <= '0;
    {fetchPc, memAddr, resId} <= {3{~v}};
  endtask
endmodule
`default_nettype wire

// file: cbdu_core_breakpoint_debug_unit_tb.sv
// self-checking bench for the core breakpoint debug unit
`timescale 1ns/10ps
`default_nettype none
module cbdu_core_breakpoint_debug_unit_tb;
  logic        core_clk, resetn, psel, penable, pwrite, pready, pslverr, debugEntry, hostDebugReq;
  logic        debugCallValid, fetchValid, memValid, memStore, resValid, inDebug, cfgScratchWrite, debugIrq;
  logic [2:0]  cfgScratchSel;
  logic [4:0]  regReadReg;
  logic [7:0]  debugCallCore, fetchCore, memCore, resCore, coreStop, regReadCore;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, savedStatusIn, savedPcIn, savedSpIn, fetchPc, memAddr, resId;
  logic [31:0] cfgScratchWdata, cfgScratchRdata, seed, r1, r2, r3, irqs;
  logic [33:0] q[$];
  logic [33:0] x;
  int          miscompares, nChecks, n, i;
  cbdu_core_breakpoint_debug_unit dut (.*);
  cbdu_core_model cores (.*);
  initial begin
    core_clk = 0;
    forever #12.5 core_clk = ~core_clk;
  end
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task cmp(input string s, input logic [31:0] e, input logic [31:0] g);
    nChecks++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", s, e, g);
    end
  endtask
  task completeRun;
    $display("checks %0d mismatches %0d", nChecks, miscompares);
    if (miscompares == 0 && nChecks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic e = 0);
    q.push_back({!w, e, d});
    psel <= 1;
    pwrite <= w;
    paddr <= {2'b00, a, 2'b00};
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1 && n < 16);
    psel <= 0;
    penable <= 0;
    @(posedge core_clk);
    if (n == 16) begin
      miscompares++;
      completeRun;
    end
  endtask
  always @(posedge core_clk) begin
    if (debugIrq === 1) irqs++;
    if (psel && penable && pready === 1) begin
      x = q.pop_front();
      cmp("pslverr", {31'h0, x[32]}, {31'h0, pslverr});
      if (x[33]) cmp("prdata", x[31:0], prdata);
    end
  end
  initial begin
    seed = 32'hF2CD241B;
    irqs = 0;
    {resetn, psel, penable, pwrite, debugEntry, hostDebugReq, debugCallValid, inDebug, cfgScratchWrite} = '0;
    {paddr, pwdata, savedStatusIn, savedPcIn, savedSpIn, debugCallCore, cfgScratchSel, cfgScratchWdata} = '0;
    repeat (5) @(posedge core_clk);
    resetn <= 1;
    @(posedge core_clk);
    bus(0, 8'h15, 0);
    bus(0, 8'h40, 0);
    bus(0, 8'h17, 0, 1);
    bus(1, 8'h13, 32'hFFFFFFFF);
    bus(1, 8'h14, 32'hFFFFFFFF);
    bus(0, 8'h13, 32'hFF);
    bus(0, 8'h14, 32'h1F);
    cmp("regReadReg", 32'h1F, {27'h0, regReadReg});
    r1 = rnd();
    r2 = rnd();
    r3 = rnd();
    {savedStatusIn, savedPcIn, savedSpIn, debugEntry} <= {r1, r2, r3, 1'b1};
    @(posedge core_clk);
    {savedStatusIn, savedPcIn, savedSpIn, debugEntry} <= {~r1, ~r2, ~r3, 1'b0};
    bus(1, 8'h10, ~r1);
    bus(0, 8'h10, r1);
    bus(0, 8'h11, r2);
    bus(1, 8'h12, r1);
    bus(0, 8'h12, r1);
    for (i = 0; i < 8; i++) begin
      r1 = rnd();
      bus(1, 8'h20 + i[7:0], r1);
      cfgScratchSel <= i[2:0];
      repeat (3) @(posedge core_clk);
      cmp("cfgScratchRdata", r1, cfgScratchRdata);
      {cfgScratchWrite, cfgScratchWdata} <= {1'b1, ~r1};
      @(posedge core_clk);
      cfgScratchWrite <= 0;
      bus(0, 8'h20 + i[7:0], ~r1);
    end
    $display("registers done");
    hostDebugReq <= 1;
    @(posedge core_clk);
    hostDebugReq <= 0;
    bus(0, 8'h15, 32'h1);
    {debugCallValid, debugCallCore} <= {1'b1, 8'h05};
    @(posedge core_clk);
    debugCallValid <= 0;
    bus(0, 8'h15, 32'h0502);
    r1 = rnd();
    for (i = 0; i < 4; i++) bus(1, 8'h30 + i[7:0], r1);
    bus(1, 8'h41, 32'h00080001);
    bus(1, 8'h42, 32'h00080001);
    bus(1, 8'h43, 32'h00080000);
    cores.issue(0, 8'h02, r1, 0);
    @(posedge core_clk);
    cores.issue(0, 8'h03, r1, 0);
    bus(0, 8'h15, 32'h00010303);
    bus(1, 8'h40, 32'h00080003);
    cores.issue(0, 8'h03, ~r1, 0);
    bus(0, 8'h15, 32'h00000303);
    bus(1, 8'h52, 32'h100);
    bus(1, 8'h62, 32'h1FF);
    bus(1, 8'h72, 32'h00020001);
    cores.issue(1, 8'h01, 32'h1FF, 1);
    bus(0, 8'h15, 32'h00020104);
    cores.issue(1, 8'h01, 32'h100, 0);
    @(posedge core_clk);
    cores.issue(1, 8'h01, 32'h200, 1);
    bus(1, 8'h72, 32'h00020005);
    cores.issue(1, 8'h01, 32'h100, 0);
    bus(0, 8'h16, 32'h100);
    bus(1, 8'h83, 32'hFF00);
    bus(1, 8'h93, 32'h1200);
    bus(1, 8'h9F, 32'h00400001);
    cores.issue(2, 8'h06, 32'h5A5A12C3, 0);
    bus(0, 8'h15, 32'h00030605);
    bus(0, 8'h16, 32'h5A5A12C3);
    $display("events done");
    bus(1, 8'h18, 32'hFFFFFF0A);
    bus(0, 8'h18, 32'h0A);
    repeat (2) @(posedge core_clk);
    cmp("coreStop", 32'h0A, {24'h0, coreStop});
    inDebug <= 1;
    repeat (3) @(posedge core_clk);
    cmp("coreStop in debug", 32'h0, {24'h0, coreStop});
    cmp("debugIrq count", 32'd7, irqs);
    completeRun;
  end
endmodule
`default_nettype wire
